// [rtl/rst_lp_map.svh]
`ifndef RST_LP_MAP_SVH
`define RST_LP_MAP_SVH
// ==========================================
// register byte offsets
`define RSS_ADDR 12'hff0
`define PWR_ADDR 12'hf80
`define LPC_ADDR 12'hf84
`define LPS_ADDR 12'hf88
// ==========================================
// status field positions
`define RSS_POR 7
`define RSS_STOP 6
`define RSS_WDT 5
`define RSS_EXT 4
`define RSS_LV 0
// power control field positions
`define PWR_AMP 7
`define PWR_BO 4
// ==========================================
// reset values and masks
`define RSS_RST 4'h8
`define PWR_RST 8'h80
`define PWR_MASK 8'h9e
`define WDC_RST 8'h00
// ==========================================
// timing counts in pclk cycles
`define PIN_FILT_CYC 4
`define RST_HOLD_CYC 16
`define SMR_CYC 66
`endif

// [rtl/rst_lp_pkg.sv]
// ==========================================
// shared types
package rst_lp_pkg;
  // power sequencing states
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_HALT,
    MODE_SLEEP,
    MODE_RECOVER,
    MODE_RESET
  } mode_t;
  // upper status flags: por, stop, wdt, ext
  typedef logic [3:0] flags_t;
endpackage : rst_lp_pkg

// [rtl/rst_lp_ctrl.sv]
// How it works
// (R1) pin low in sleep forces system reset
// (R2) short pin pulses filtered out
// (R3) low-voltage flag follows live comparator
// (R4) flag unlatched, access never changes it
// (R5) enabled low-voltage raises interrupt
// (R6) brownout off kills low-voltage flag, interrupt
// (R7) status read-only, writes reach watchdog control
// (R8) status read clears four upper flags
// (R9) power-on flag set/clear conditions
// (R10) sleep-recovery flag set/clear conditions
// (R11) watchdog flag set/clear; read before clear
// (R12) pin-reset flag set/clear conditions
// (R13) reserved status bits read zero
// (R14) upper flags use fixed event codes
// (R15) debugger resets report as power-on
// (R16) sleep stops clocks, oscillators, cpu
// (R17) sleep releases crystal pins
// (R18) sleep keeps only enabled keep-alive blocks
// (R19) halt stops cpu only
// (R20) halt exits on interrupt, timeout, resets
// (R21) peripherals individually disableable
// (R22) wake pin or timeout gives recovery
// (R23) debugger reset bit self-clears in reset
// (R24) comparator input double synchronised
// (R25) new event beats a coincident read
//
// The APB register port was left to the implementer.
`include "rst_lp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rst_lp_ctrl #(
  parameter int unsigned WAKE_W = 8,
  parameter int unsigned PIN_FILT = `PIN_FILT_CYC,
  parameter int unsigned RST_HOLD = `RST_HOLD_CYC,
  parameter int unsigned SMR_HOLD = `SMR_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // cpu and on-chip sources
  input wire logic stop_exec,
  input wire logic halt_exec,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic wdt_reset_mode,
  input wire logic wdt_enable,
  input wire logic wdt_osc_enable,
  input wire logic brownout_reset,
  input wire logic brownout_sleep_option,
  input wire logic dbg_reset_req,
  input wire logic [WAKE_W-1:0] wake_en,
  // asynchronous pins
  input wire logic reset_pin_n,
  input wire logic debugger_pin_n,
  input wire logic low_voltage_cmp,
  input wire logic [WAKE_W-1:0] wake_pins,
  // power and reset controls
  output logic cpu_run,
  output logic sysclk_run,
  output logic osc_run,
  output logic crystal_pins_release,
  output logic wdt_run,
  output logic brownout_run,
  output logic amp_run,
  output logic [7:0] periph_disable,
  output logic sys_reset_n,
  output logic cpu_reset,
  output logic dbg_reset_clear,
  // status and watchdog control
  output logic low_voltage_flag,
  output logic low_voltage_irq,
  output logic wdt_ctrl_wr,
  output logic [7:0] watchdog_control
);
  import rst_lp_pkg::*;

  // ==========================================
  // constants
  localparam logic [7:0] FILT_M1 = 8'(PIN_FILT - 1);
  localparam logic [7:0] RST_C = 8'(RST_HOLD);
  localparam logic [7:0] SMR_C = 8'(SMR_HOLD);

  // all state of the block
  typedef struct packed {
    mode_t mode;
    logic [1:0] pin_s;   // reset pin sync
    logic [1:0] dbg_s;   // debugger pin sync
    logic [1:0] lv_s;    // comparator sync
    logic [WAKE_W-1:0] wk_s0;
    logic [WAKE_W-1:0] wk_s1;
    logic [WAKE_W-1:0] wk_d;  // last synced level
    logic [7:0] filt;    // pin low run length
    logic [7:0] hold;    // reset or recovery wait
    flags_t flags;
    logic [7:0] wdc;     // watchdog control copy
    logic [7:0] pwr;     // peripheral disables
    logic lv_ien;        // low-voltage irq enable
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cpu_run;
    logic clk_run;
    logic osc_run;
    logic xtal_rel;
    logic wdt_run;
    logic bo_run;
    logic amp_run;
    logic sys_rst_n;
    logic cpu_rst;
    logic dbg_clr;
    logic lv_flag;
    logic lv_irq;
    logic wdc_wr;
  } state_t;

  state_t s_ff;   // registered state
  state_t nxt_s;  // next state

  // ==========================================
  // address decode
  function automatic logic addr_hit(input logic [11:0] a);
    if (a == `RSS_ADDR) begin
      addr_hit = 1'b1;
    end else if (a == `PWR_ADDR) begin
      addr_hit = 1'b1;
    end else if (a == `LPC_ADDR) begin
      addr_hit = 1'b1;
    end else if (a == `LPS_ADDR) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  endfunction : addr_hit

  // events and helpers, shared with checks
  logic setup;      // apb setup cycle
  logic acc;        // apb access completes
  logic rd_stat;    // status read completes
  logic sleeping;
  logic pin_low;
  logic pin_rst;    // filtered pin reset
  logic por_like;   // reported as power-on
  logic wdt_rst;    // watchdog reset outside sleep
  logic wake_any;   // enabled wake pin changed
  logic any_rst;
  logic ev_any;     // any flag-writing event

  // ==========================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    setup = psel && !penable;
    acc = psel && penable && s_ff.pready;
    rd_stat = acc && !pwrite && paddr == `RSS_ADDR;
    sleeping = s_ff.mode == MODE_SLEEP;
    // two-flop synchronisers
    nxt_s.pin_s = {s_ff.pin_s[0], reset_pin_n};
    nxt_s.dbg_s = {s_ff.dbg_s[0], debugger_pin_n};
    nxt_s.lv_s = {s_ff.lv_s[0], low_voltage_cmp};  // see (R24)
    nxt_s.wk_s0 = wake_pins;
    nxt_s.wk_s1 = s_ff.wk_s0;
    nxt_s.wk_d = s_ff.wk_s1;
    // glitch filter on the reset pin
    pin_low = !s_ff.pin_s[1];
    if (!pin_low) begin
      nxt_s.filt = 8'h00;
    end else if (s_ff.filt < FILT_M1) begin
      nxt_s.filt = s_ff.filt + 8'h01;
    end
    pin_rst = pin_low && s_ff.filt >= FILT_M1;  // see (R1) (R2)
    // debugger request, brownout, or debugger pin in sleep
    por_like = dbg_reset_req || brownout_reset
      || (sleeping && !s_ff.dbg_s[1]);  // see (R15)
    wdt_rst = wdt_timeout && wdt_reset_mode && !sleeping;
    wake_any = |((s_ff.wk_s1 ^ s_ff.wk_d) & wake_en);
    any_rst = por_like || pin_rst || wdt_rst;
    ev_any = any_rst || wdt_timeout || (sleeping && wake_any);
    // clear only flags that the read returned
    if (rd_stat) begin
      nxt_s.flags = s_ff.flags & ~s_ff.prdata[7:4];  // see (R8)
    end
    // events override the read clear
    if (por_like) begin
      nxt_s.flags = 4'b1000;  // see (R9) (R14) (R15)
    end else if (pin_rst) begin
      nxt_s.flags = 4'b0001;  // see (R12) (R14)
    end else if (wdt_timeout && !sleeping) begin
      // reset mode gives 0010, irq mode keeps ext
      nxt_s.flags = {3'b001, nxt_s.flags[0] && !wdt_reset_mode};  // see (R10) (R11)
    end else if (sleeping && wdt_timeout) begin
      nxt_s.flags = 4'b0110;  // see (R14) (R22) (R25)
    end else if (sleeping && wake_any) begin
      nxt_s.flags = 4'b0100;  // see (R10) (R11) (R12)
    end
    // mode sequencing
    case (s_ff.mode)
      MODE_ACTIVE: begin
        if (stop_exec) begin
          nxt_s.mode = MODE_SLEEP;  // see (R16)
        end else if (halt_exec) begin
          nxt_s.mode = MODE_HALT;  // see (R19)
        end
      end
      MODE_HALT: begin
        if (irq_pending || wdt_timeout) begin
          nxt_s.mode = MODE_ACTIVE;  // see (R20)
        end
      end
      MODE_SLEEP: begin
        if (wake_any || wdt_timeout) begin
          nxt_s.mode = MODE_RECOVER;  // see (R22)
          nxt_s.hold = SMR_C;
        end
      end
      MODE_RECOVER, MODE_RESET: begin
        if (s_ff.hold <= 8'h01) begin
          nxt_s.mode = MODE_ACTIVE;
        end else begin
          nxt_s.hold = s_ff.hold - 8'h01;
        end
      end
      default: begin
        nxt_s.mode = MODE_ACTIVE;
      end
    endcase
    // resets take over any mode
    if (any_rst) begin
      nxt_s.mode = MODE_RESET;  // see (R1) (R20)
      nxt_s.hold = RST_C;
    end
    // apb: zero wait, answer registered at setup
    nxt_s.pready = setup;
    nxt_s.pslverr = setup && !addr_hit(paddr);
    nxt_s.prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (paddr == `RSS_ADDR) begin
        // reserved bits read zero
        nxt_s.prdata[7:0] = {s_ff.flags, 3'b000, s_ff.lv_flag};  // see (R13)
      end else if (paddr == `PWR_ADDR) begin
        nxt_s.prdata[7:0] = s_ff.pwr;
      end else if (paddr == `LPC_ADDR) begin
        nxt_s.prdata[0] = s_ff.lv_ien;
      end else if (paddr == `LPS_ADDR) begin
        nxt_s.prdata[2:0] = s_ff.mode;
      end
    end
    // writes land at the access edge
    nxt_s.wdc_wr = 1'b0;
    if (acc && pwrite) begin
      if (paddr == `RSS_ADDR) begin
        nxt_s.wdc = pwdata[7:0];  // see (R7) (R4)
        nxt_s.wdc_wr = 1'b1;
      end else if (paddr == `PWR_ADDR) begin
        nxt_s.pwr = pwdata[7:0] & `PWR_MASK;  // see (R21)
      end else if (paddr == `LPC_ADDR) begin
        nxt_s.lv_ien = pwdata[0];
      end
    end
    // power controls follow the next mode
    nxt_s.cpu_run = nxt_s.mode == MODE_ACTIVE;  // see (R16) (R19)
    nxt_s.clk_run = nxt_s.mode != MODE_SLEEP;  // see (R16)
    nxt_s.osc_run = nxt_s.mode != MODE_SLEEP;
    nxt_s.xtal_rel = nxt_s.mode == MODE_SLEEP;  // see (R17)
    if (nxt_s.mode == MODE_SLEEP) begin
      nxt_s.wdt_run = wdt_enable && wdt_osc_enable;  // see (R18)
      nxt_s.bo_run = !nxt_s.pwr[`PWR_BO] && brownout_sleep_option;
    end else begin
      nxt_s.wdt_run = wdt_enable;
      nxt_s.bo_run = !nxt_s.pwr[`PWR_BO];
    end
    nxt_s.amp_run = !nxt_s.pwr[`PWR_AMP];  // see (R18)
    nxt_s.sys_rst_n = nxt_s.mode != MODE_RESET;
    nxt_s.cpu_rst = nxt_s.mode == MODE_RESET || nxt_s.mode == MODE_RECOVER;
    nxt_s.dbg_clr = nxt_s.mode == MODE_RESET;  // see (R23)
    // live flag, gated by the brownout block
    nxt_s.lv_flag = s_ff.lv_s[1] && nxt_s.bo_run;  // see (R3) (R6)
    nxt_s.lv_irq = nxt_s.lv_flag && nxt_s.lv_ien;  // see (R5)
  end

  // ==========================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.mode <= MODE_RESET;
      s_ff.hold <= 8'(`RST_HOLD_CYC);
      s_ff.pin_s <= 2'b11;
      s_ff.dbg_s <= 2'b11;
      s_ff.flags <= `RSS_RST;
      s_ff.wdc <= `WDC_RST;
      s_ff.pwr <= `PWR_RST;
      s_ff.cpu_rst <= 1'b1;
      s_ff.dbg_clr <= 1'b1;
      s_ff.clk_run <= 1'b1;
      s_ff.osc_run <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================
  // outputs straight from the state register
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign prdata = s_ff.prdata;
  assign cpu_run = s_ff.cpu_run;
  assign sysclk_run = s_ff.clk_run;
  assign osc_run = s_ff.osc_run;
  assign crystal_pins_release = s_ff.xtal_rel;
  assign wdt_run = s_ff.wdt_run;
  assign brownout_run = s_ff.bo_run;
  assign amp_run = s_ff.amp_run;
  assign periph_disable = s_ff.pwr;
  assign sys_reset_n = s_ff.sys_rst_n;
  assign cpu_reset = s_ff.cpu_rst;
  assign dbg_reset_clear = s_ff.dbg_clr;
  assign low_voltage_flag = s_ff.lv_flag;
  assign low_voltage_irq = s_ff.lv_irq;
  assign wdt_ctrl_wr = s_ff.wdc_wr;
  assign watchdog_control = s_ff.wdc;

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_read_clears: assert property (rd_stat && !ev_any |=> (s_ff.flags & s_ff.prdata[7:4]) == 4'h0 || 1'b1 ? s_ff.flags == ($past(s_ff.flags) & ~$past(s_ff.prdata[7:4])) : 1'b0) // see (R8)
    else $error("status read did not clear flags");
  a_por_code: assert property (por_like |=> s_ff.flags == 4'b1000 && !s_ff.sys_rst_n) // see (R15)
    else $error("debugger reset not reported as power-on");
  a_pin_code: assert property (pin_rst && !por_like |=> s_ff.flags == 4'b0001) // see (R12)
    else $error("pin reset code wrong");
  a_wake_code: assert property (sleeping && wake_any && !wdt_timeout && !any_rst |=> s_ff.flags == 4'b0100 && s_ff.mode == MODE_RECOVER) // see (R22)
    else $error("pin wake did not start recovery");
  a_pin_filter: assert property (pin_rst |-> !$past(s_ff.pin_s[1], 3) && pin_low) // see (R2)
    else $error("short pin pulse caused reset");
  a_sleep_clocks: assert property (s_ff.mode == MODE_SLEEP |-> !s_ff.clk_run && !s_ff.osc_run && !s_ff.cpu_run && s_ff.xtal_rel) // see (R16)
    else $error("clocks still running in sleep");
  a_halt_clocks: assert property (s_ff.mode == MODE_HALT |-> s_ff.clk_run && !s_ff.cpu_run) // see (R19)
    else $error("halt state controls wrong");
  a_lv_gate: assert property (!s_ff.bo_run |-> !s_ff.lv_flag && !s_ff.lv_irq) // see (R6)
    else $error("low-voltage active with brownout off");
  a_lv_live: assert property (s_ff.lv_s[1] && s_ff.bo_run && nxt_s.bo_run |=> s_ff.lv_flag) // see (R3)
    else $error("low-voltage flag not live");
  a_halt_exit: assert property (s_ff.mode == MODE_HALT && irq_pending && !any_rst |=> s_ff.cpu_run) // see (R20)
    else $error("interrupt did not end halt");
endmodule : rst_lp_ctrl
`default_nettype wire

// [sim/cpu_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// processor core model: register access and instruction strobes
module cpu_core_model (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // instruction strobes, one cycle each
  output logic stop_exec,
  output logic halt_exec
);
  // idle bus and no instruction at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stop_exec = 1'b0;
    halt_exec = 1'b0;
  end
  // setup then access, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep the last value
    paddr <= ~a;
    pwdata <= ~wd;
    if (i == 50) begin
      reset_status_and_low_power_modes_bench.chk(32'h0, 32'h1);
      reset_status_and_low_power_modes_bench.end_of_test();
    end
  endtask : xfer
  // sleep instruction, or halt when h is set
  task automatic instr(input logic h);
    @(posedge pclk);
    stop_exec <= ~h;
    halt_exec <= h;
    @(posedge pclk);
    stop_exec <= 1'b0;
    halt_exec <= 1'b0;
  endtask : instr
endmodule : cpu_core_model
`default_nettype wire

// [sim/reset_status_and_low_power_modes_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench top for the reset status and power mode block
module reset_status_and_low_power_modes_bench;
  import rst_lp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, stop_exec, halt_exec;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic irq_pending = 1'b0, wdt_timeout = 1'b0, brownout_reset = 1'b0, dbg_reset_req = 1'b0;
  logic reset_pin_n = 1'b1, debugger_pin_n = 1'b1, low_voltage_cmp = 1'b0;
  logic wdt_reset_mode = 1'b1, wdt_enable = 1'b1, wdt_osc_enable = 1'b1;
  logic brownout_sleep_option = 1'b1;
  logic [7:0] wake_en = 8'h00, wake_pins = 8'h00, periph_disable, watchdog_control;
  logic cpu_run, sysclk_run, osc_run, crystal_pins_release, wdt_run, brownout_run, amp_run;
  logic sys_reset_n, cpu_reset, dbg_reset_clear, low_voltage_flag, low_voltage_irq, wdt_ctrl_wr;
  // model: m holds upper flags, lv the live voltage bit
  int miscompares = 0, cmp_count = 0, m = 8, lv = 0, k, r;
  always #20 pclk = ~pclk;
  // ==========================================
  // design and core model
  rst_lp_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .stop_exec, .halt_exec, .irq_pending, .wdt_timeout,
    .wdt_reset_mode, .wdt_enable, .wdt_osc_enable, .brownout_reset,
    .brownout_sleep_option, .dbg_reset_req, .wake_en, .reset_pin_n, .debugger_pin_n,
    .low_voltage_cmp, .wake_pins, .cpu_run, .sysclk_run, .osc_run, .crystal_pins_release,
    .wdt_run, .brownout_run, .amp_run, .periph_disable, .sys_reset_n, .cpu_reset,
    .dbg_reset_clear, .low_voltage_flag, .low_voltage_irq, .wdt_ctrl_wr, .watchdog_control);
  cpu_core_model core (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .stop_exec, .halt_exec);
  // ==========================================
  // checking helpers
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // access with data and response compared
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd,
      input logic [31:0] exp, input logic err);
    logic [31:0] d;
    logic e;
    core.xfer(w, a, wd, d, e);
    chk(d, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : acc
  // status read, then model flags cleared
  task automatic rd_stat();
    acc(1'b0, 12'hff0, 32'h0, {24'h0, m[3:0], 3'b000, lv[0]}, 1'b0);
    m = 0;
  endtask : rd_stat
  function automatic logic sel(input int w);
    return w == 0 ? cpu_run : dbg_reset_clear;
  endfunction : sel
  // bounded wait on a design level
  task automatic wait_for(input int w, input logic v);
    int i;
    for (i = 0; i < 400 && sel(w) !== v; i++) @(posedge pclk);
    if (i == 400) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : wait_for
  // one reset or recovery source, optionally from deep sleep
  task automatic ev(input int kind, input logic slp, input int code);
    if (slp) begin
      core.instr(1'b0);
      @(posedge pclk);
      #1;
      chk({sysclk_run, osc_run, cpu_run, crystal_pins_release}, 4'b0001);
      chk({wdt_run, brownout_run, amp_run}, 3'b110);
    end
    @(posedge pclk);
    case (kind)
      0: reset_pin_n <= 1'b0;
      1: debugger_pin_n <= 1'b0;
      2: wdt_timeout <= 1'b1;
      3: wake_pins[k] <= ~wake_pins[k];
      4: dbg_reset_req <= 1'b1;
      default: brownout_reset <= 1'b1;
    endcase
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    brownout_reset <= 1'b0;
    if (kind == 4) wait_for(1, 1'b1);
    repeat (7) @(posedge pclk);
    chk({sys_reset_n, cpu_reset}, {code[2], 1'b1});
    reset_pin_n <= 1'b1;
    debugger_pin_n <= 1'b1;
    dbg_reset_req <= 1'b0;
    wait_for(0, 1'b1);
    m = code;
    rd_stat();
  endtask : ev
  // ==========================================
  // main sequence
  initial begin
    r = $urandom(67);
    k = $urandom % 8;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wake_en <= 8'h01 << k;
    wait_for(0, 1'b1);
    chk(periph_disable, 8'h80);
    rd_stat();
    rd_stat();
    acc(1'b0, 12'hf8c, 32'h0, 32'h0, 1'b1);
    r = $urandom & 32'hff;
    acc(1'b1, 12'hff0, r, 32'h0, 1'b0);
    #1;
    chk(wdt_ctrl_wr, 1'b1);
    rd_stat();
    chk(watchdog_control, r[7:0]);
    r = $urandom & 32'h9e;
    acc(1'b1, 12'hf80, r, 32'h0, 1'b0);
    acc(1'b0, 12'hf80, 32'h0, r, 1'b0);
    chk(periph_disable, r[7:0]);
    acc(1'b1, 12'hf80, 32'h80, 32'h0, 1'b0);
    // low-voltage flag, interrupt and brownout gating
    @(posedge pclk);
    low_voltage_cmp <= 1'b1;
    lv = 1;
    repeat (4) @(posedge pclk);
    chk(low_voltage_flag, 1'b1);
    acc(1'b1, 12'hf84, 32'h1, 32'h0, 1'b0);
    rd_stat();
    acc(1'b1, 12'hff0, 32'h0, 32'h0, 1'b0);
    rd_stat();
    chk(low_voltage_irq, 1'b1);
    acc(1'b1, 12'hf80, 32'h90, 32'h0, 1'b0);
    lv = 0;
    rd_stat();
    chk({low_voltage_flag, low_voltage_irq}, 2'b00);
    acc(1'b1, 12'hf80, 32'h80, 32'h0, 1'b0);
    low_voltage_cmp <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(low_voltage_flag, 1'b0);
    // short pin pulse in sleep is ignored, then watchdog wake
    core.instr(1'b0);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (2) @(posedge pclk);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({sys_reset_n, cpu_run}, 2'b10);
    ev(2, 1'b0, 6);
    ev(3, 1'b1, 4);
    ev(0, 1'b1, 1);
    ev(1, 1'b1, 8);
    ev(4, 1'b0, 8);
    ev(2, 1'b0, 2);
    // watchdog in interrupt mode sets its flag without a reset
    @(posedge pclk);
    wdt_reset_mode <= 1'b0;
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    wdt_reset_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk({sys_reset_n, cpu_run}, 2'b11);
    m = 2;
    rd_stat();
    // halt keeps clocks, exits on interrupt or brownout
    core.instr(1'b1);
    @(posedge pclk);
    #1;
    chk({cpu_run, sysclk_run, osc_run, wdt_run}, 4'b0111);
    @(posedge pclk);
    irq_pending <= 1'b1;
    wait_for(0, 1'b1);
    irq_pending <= 1'b0;
    core.instr(1'b1);
    ev(5, 1'b0, 8);
    end_of_test();
  end
endmodule : reset_status_and_low_power_modes_bench
`default_nettype wire
